// [src/i2cs_pkg.sv]
/*
  Constants, register map and state type for the two-wire slave block.
  Assumes a 32-bit APB master and one 100 MHz clock.
*/
`default_nettype none

package i2cs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0   = 8'h00;
  localparam logic [7:0] OFS_CTRL1   = 8'h04;
  localparam logic [7:0] OFS_DATA    = 8'h08;
  localparam logic [7:0] OFS_ADDR    = 8'h0C;
  localparam logic [7:0] OFS_TOCTRL  = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE      = 0;
  localparam int BIT_ACK_RX      = 0;
  localparam int BIT_MASTER_READ = 2;
  localparam int BIT_ACK_TO_SEND = 3;
  localparam int BIT_TX_DIR      = 4;
  localparam int BIT_BUSY        = 5;
  localparam int BIT_MATCHED     = 6;
  localparam int BIT_TO_ENABLE   = 7;
  localparam int BIT_TO_FLAG     = 6;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL0   = 8'h00;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [6:0] RST_ADDR    = 7'h00;
  localparam logic [5:0] RST_TOSEL   = 6'h00;
  localparam int         SUB_DIV     = 32;
  localparam logic [3:0] ADDR_BITS   = 4'h8;
  localparam logic [3:0] DATA_BITS   = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_STRETCH,
    ST_RX_BITS,
    ST_RX_ACK,
    ST_TX_BITS,
    ST_TX_ACK,
    ST_IGNORE
  } i2cs_state_type;

endpackage

`default_nettype wire

// [src/i2cs_sub_div.sv]
/*
  Divider that turns subsidiary clock ticks into one tick per DIV of them.
  Assumes sub_tick is a one-cycle strobe synchronous to ref_clk.
*/
`default_nettype none

module i2cs_sub_div #(
  parameter int DIV = 32
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic sub_tick,
  output logic      tick
);

  logic [$clog2(DIV)-1:0] cnt_reg;
  logic [$clog2(DIV)-1:0] cnt_next;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (sub_tick) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = !clear && sub_tick && (cnt_reg == ($clog2(DIV))'(DIV - 1));

endmodule // i2cs_sub_div

`default_nettype wire

// [src/i2cs_slave.sv]
/*
  Two-wire bus slave with address match, byte transfer, clock stretching
  and bus time-out, reached by software over APB.
  Assumes scl_in, sda_in and sub_tick are synchronous to ref_clk.
*/
`default_nettype none

module i2cs_slave (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        sub_tick,
  output logic             bus_irq
);

  i2cs_pkg::i2cs_state_type state_reg, state_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  shift_data_reg, shift_data_next;
  logic [6:0]  own_address_reg, own_address_next;
  logic [7:0]  module_control_reg_0, module_control_next_0;
  logic        ack_received_flag_reg, ack_received_flag_next;
  logic        master_read_flag_reg, master_read_flag_next;
  logic        ack_to_send_reg, ack_to_send_next;
  logic        transmit_direction_reg, transmit_direction_next;
  logic        bus_busy_flag_reg, bus_busy_flag_next;
  logic        address_matched_flag_reg, address_matched_flag_next;
  logic        timeout_enable_reg, timeout_enable_next;
  logic        timeout_flag_reg, timeout_flag_next;
  logic [5:0]  timeout_period_select_reg, timeout_period_select_next;
  logic [6:0]  to_cnt_reg, to_cnt_next;
  logic        to_run_reg, to_run_next;
  logic        scl_q_reg, sda_q_reg;
  logic        irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        scl_rise, scl_fall, start_det, stop_det;
  logic        acc, wr, rd, mapped, addr_hit, to_tick, to_expire;
  logic [7:0]  module_control_status_reg_1, bus_timeout_control;

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  assign scl_rise  = !scl_q_reg && scl_in;
  assign scl_fall  = scl_q_reg && !scl_in;
  assign start_det = scl_q_reg && scl_in && sda_q_reg && !sda_in;
  assign stop_det  = scl_q_reg && scl_in && !sda_q_reg && sda_in;
  assign addr_hit  = shift_reg[7:1] == own_address_reg;

  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign mapped = paddr == i2cs_pkg::OFS_CTRL0 || paddr == i2cs_pkg::OFS_CTRL1
               || paddr == i2cs_pkg::OFS_DATA || paddr == i2cs_pkg::OFS_ADDR
               || paddr == i2cs_pkg::OFS_TOCTRL;

  assign module_control_status_reg_1 = {1'b0, address_matched_flag_reg, bus_busy_flag_reg,
    transmit_direction_reg, ack_to_send_reg, master_read_flag_reg, 1'b0,
    ack_received_flag_reg};
  assign bus_timeout_control = {timeout_enable_reg, timeout_flag_reg,
    timeout_period_select_reg};

  i2cs_sub_div #(
    .DIV(i2cs_pkg::SUB_DIV)
  ) u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (scl_fall || !to_run_reg),
    .sub_tick(sub_tick),
    .tick    (to_tick)
  );

  assign to_expire = to_run_reg && timeout_enable_reg && to_tick && !scl_fall
    && (to_cnt_reg == {1'b0, timeout_period_select_reg});

  // ----------------------------------------------------------------
  // Bus engine, registers and time-out
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    shift_data_next = shift_data_reg;
    own_address_next = own_address_reg;
    module_control_next_0 = module_control_reg_0;
    ack_received_flag_next = ack_received_flag_reg;
    master_read_flag_next = master_read_flag_reg;
    ack_to_send_next = ack_to_send_reg;
    transmit_direction_next = transmit_direction_reg;
    bus_busy_flag_next = bus_busy_flag_reg;
    address_matched_flag_next = address_matched_flag_reg;
    timeout_enable_next = timeout_enable_reg;
    timeout_period_select_next = timeout_period_select_reg;
    to_cnt_next = to_cnt_reg;
    to_run_next = to_run_reg;
    irq_next = 1'b0;
    if (wr && paddr == i2cs_pkg::OFS_CTRL0) begin
      module_control_next_0 = pwdata[7:0];
    end
    if (wr && paddr == i2cs_pkg::OFS_ADDR) begin
      own_address_next = pwdata[7:1];
    end
    if (wr && paddr == i2cs_pkg::OFS_CTRL1) begin
      ack_to_send_next = pwdata[i2cs_pkg::BIT_ACK_TO_SEND];
      transmit_direction_next = pwdata[i2cs_pkg::BIT_TX_DIR];
    end
    if (wr && paddr == i2cs_pkg::OFS_DATA) begin
      shift_data_next = pwdata[7:0];
    end
    if (wr && paddr == i2cs_pkg::OFS_TOCTRL) begin
      timeout_enable_next = pwdata[i2cs_pkg::BIT_TO_ENABLE];
      timeout_period_select_next = pwdata[5:0];
    end
    case (state_reg)
      i2cs_pkg::ST_ADDR: begin
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_in};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (scl_fall && bit_cnt_reg == i2cs_pkg::ADDR_BITS) begin
          if (addr_hit) begin
            address_matched_flag_next = 1'b1;
            master_read_flag_next = shift_reg[0];
            irq_next = 1'b1;
            to_run_next = 1'b1;
            to_cnt_next = '0;
            state_next = i2cs_pkg::ST_ADDR_ACK;
          end else begin
            state_next = i2cs_pkg::ST_IGNORE;
          end
        end
      end
      i2cs_pkg::ST_ADDR_ACK: begin
        if (scl_fall) begin
          state_next = i2cs_pkg::ST_STRETCH;
        end
      end
      i2cs_pkg::ST_STRETCH: begin
        if (wr && paddr == i2cs_pkg::OFS_DATA && transmit_direction_reg) begin
          shift_next = pwdata[7:0];
          bit_cnt_next = '0;
          address_matched_flag_next = 1'b0;
          state_next = i2cs_pkg::ST_TX_BITS;
        end else if (rd && paddr == i2cs_pkg::OFS_DATA && !transmit_direction_reg) begin
          bit_cnt_next = '0;
          address_matched_flag_next = 1'b0;
          state_next = i2cs_pkg::ST_RX_BITS;
        end
      end
      i2cs_pkg::ST_RX_BITS: begin
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_in};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (scl_fall && bit_cnt_reg == i2cs_pkg::DATA_BITS) begin
          shift_data_next = shift_reg;
          state_next = i2cs_pkg::ST_RX_ACK;
        end
      end
      i2cs_pkg::ST_RX_ACK: begin
        if (scl_fall) begin
          irq_next = 1'b1;
          state_next = i2cs_pkg::ST_STRETCH;
        end
      end
      i2cs_pkg::ST_TX_BITS: begin
        if (scl_fall) begin
          shift_next = {shift_reg[6:0], 1'b0};
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == i2cs_pkg::DATA_BITS - 4'h1) begin
            state_next = i2cs_pkg::ST_TX_ACK;
          end
        end
      end
      i2cs_pkg::ST_TX_ACK: begin
        if (scl_rise) begin
          ack_received_flag_next = sda_in;
        end else if (scl_fall) begin
          irq_next = 1'b1;
          state_next = ack_received_flag_reg ? i2cs_pkg::ST_IGNORE : i2cs_pkg::ST_STRETCH;
        end
      end
      default: begin
      end
    endcase
    if (scl_fall) begin
      to_cnt_next = '0;
    end else if (to_tick && to_run_reg && timeout_enable_reg) begin
      to_cnt_next = to_cnt_reg + 7'h01;
    end
    if (start_det) begin
      bus_busy_flag_next = 1'b1;
      bit_cnt_next = '0;
      to_run_next = 1'b0;
      state_next = i2cs_pkg::ST_ADDR;
    end else if (stop_det) begin
      bus_busy_flag_next = 1'b0;
      to_run_next = 1'b0;
      state_next = i2cs_pkg::ST_IDLE;
    end
    if (!module_control_reg_0[i2cs_pkg::BIT_ENABLE]) begin
      state_next = i2cs_pkg::ST_IDLE;
      to_run_next = 1'b0;
    end
    if (to_expire) begin
      to_run_next = 1'b0;
      timeout_enable_next = 1'b0;
      irq_next = 1'b1;
      to_cnt_next = '0;
      // Bus logic and control status reset.
      state_next = i2cs_pkg::ST_IDLE;
      ack_received_flag_next = 1'b0;
      master_read_flag_next = 1'b0;
      ack_to_send_next = 1'b0;
      transmit_direction_next = 1'b0;
      bus_busy_flag_next = 1'b0;
      address_matched_flag_next = 1'b0;
    end
    // Software clear; a new time-out wins.
    timeout_flag_next = to_expire ? 1'b1 : (wr && paddr == i2cs_pkg::OFS_TOCTRL)
      ? pwdata[i2cs_pkg::BIT_TO_FLAG] : timeout_flag_reg;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= i2cs_pkg::ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      shift_data_reg <= i2cs_pkg::RST_DATA;
      own_address_reg <= i2cs_pkg::RST_ADDR;
      module_control_reg_0 <= i2cs_pkg::RST_CTRL0;
      ack_received_flag_reg <= 1'b0;
      master_read_flag_reg <= 1'b0;
      ack_to_send_reg <= 1'b0;
      transmit_direction_reg <= 1'b0;
      bus_busy_flag_reg <= 1'b0;
      address_matched_flag_reg <= 1'b0;
      timeout_enable_reg <= 1'b0;
      timeout_flag_reg <= 1'b0;
      timeout_period_select_reg <= i2cs_pkg::RST_TOSEL;
      to_cnt_reg <= '0;
      to_run_reg <= 1'b0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      shift_data_reg <= shift_data_next;
      own_address_reg <= own_address_next;
      module_control_reg_0 <= module_control_next_0;
      ack_received_flag_reg <= ack_received_flag_next;
      master_read_flag_reg <= master_read_flag_next;
      ack_to_send_reg <= ack_to_send_next;
      transmit_direction_reg <= transmit_direction_next;
      bus_busy_flag_reg <= bus_busy_flag_next;
      address_matched_flag_reg <= address_matched_flag_next;
      timeout_enable_reg <= timeout_enable_next;
      timeout_flag_reg <= timeout_flag_next;
      timeout_period_select_reg <= timeout_period_select_next;
      to_cnt_reg <= to_cnt_next;
      to_run_reg <= to_run_next;
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // APB read data
  // ----------------------------------------------------------------
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable) begin
      case (paddr)
        i2cs_pkg::OFS_CTRL0:  prdata_next = {24'h000000, module_control_reg_0};
        i2cs_pkg::OFS_CTRL1:  prdata_next = {24'h000000, module_control_status_reg_1};
        i2cs_pkg::OFS_DATA:   prdata_next = {24'h000000, shift_data_reg};
        i2cs_pkg::OFS_ADDR:   prdata_next = {24'h000000, own_address_reg, 1'b0};
        i2cs_pkg::OFS_TOCTRL: prdata_next = {24'h000000, bus_timeout_control};
        default:              prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign bus_irq = irq_reg;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = state_reg != i2cs_pkg::ST_STRETCH;
  // Address ack; data ack; transmitted zero bits.
  assign sda_oe_n = !((state_reg == i2cs_pkg::ST_ADDR_ACK)
    || (state_reg == i2cs_pkg::ST_RX_ACK && !ack_to_send_reg)
    || (state_reg == i2cs_pkg::ST_TX_BITS && !shift_reg[7]));

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic match_ev;
  assign match_ev = state_reg == i2cs_pkg::ST_ADDR && scl_fall && !start_det && !stop_det
    && bit_cnt_reg == i2cs_pkg::ADDR_BITS && !to_expire
    && module_control_reg_0[i2cs_pkg::BIT_ENABLE];

  addr_match_a: assert property (match_ev && addr_hit |=> address_matched_flag_reg && bus_irq)
    else $error("address match did not flag and interrupt");
  match_flag_a: assert property ($rose(address_matched_flag_reg) |-> $past(addr_hit))
    else $error("match flag set without equal address");
  rw_capture_a: assert property (match_ev && addr_hit |=> master_read_flag_reg == $past(shift_reg[0]))
    else $error("direction bit not captured");
  addr_ack_a: assert property (state_reg == i2cs_pkg::ST_ADDR_ACK |-> !sda_oe_n && !sda_out)
    else $error("address ack not driven low");
  nomatch_a: assert property (match_ev && !addr_hit |=> !bus_irq && sda_oe_n [*2])
    else $error("mismatched address not ignored");
  stretch_a: assert property (state_reg == i2cs_pkg::ST_ADDR_ACK && scl_fall && !start_det
    && !stop_det && !to_expire && module_control_reg_0[i2cs_pkg::BIT_ENABLE]
    |=> !scl_oe_n)
    else $error("SCL not stretched after address");
  tx_first_a: assert property (state_reg == i2cs_pkg::ST_STRETCH && wr && paddr == i2cs_pkg::OFS_DATA
    && transmit_direction_reg && !start_det && !stop_det && !to_expire
    && module_control_reg_0[i2cs_pkg::BIT_ENABLE]
    |=> sda_oe_n == $past(pwdata[7]) && scl_oe_n)
    else $error("first transmitted bit is not the MSB");
  rx_ack_a: assert property (state_reg == i2cs_pkg::ST_RX_ACK && !ack_to_send_reg
    |-> !sda_oe_n)
    else $error("receiver ack not driven");
  nack_release_a: assert property (state_reg == i2cs_pkg::ST_TX_ACK && scl_fall
    && ack_received_flag_reg && !start_det && !to_expire |=> sda_oe_n)
    else $error("SDA not released after no ack");
  to_clear_a: assert property (scl_fall |=> to_cnt_reg == 7'h00)
    else $error("time-out count not cleared by SCL fall");
  stop_halt_a: assert property (stop_det |=> !to_run_reg && !bus_busy_flag_reg)
    else $error("STOP did not halt time-out");
  to_expire_a: assert property (to_expire |=> !timeout_enable_reg && timeout_flag_reg
    && bus_irq && module_control_status_reg_1 == 8'h00 && state_reg == i2cs_pkg::ST_IDLE)
    else $error("time-out overflow handling wrong");
  start_busy_a: assert property (start_det && !to_expire |=> bus_busy_flag_reg)
    else $error("START did not set busy");

  match_cov: cover property (match_ev && addr_hit);
  tx_nack_cov: cover property (state_reg == i2cs_pkg::ST_TX_ACK ##1 state_reg == i2cs_pkg::ST_IGNORE);
  rx_byte_cov: cover property (state_reg == i2cs_pkg::ST_RX_ACK ##1 state_reg == i2cs_pkg::ST_STRETCH);
  timeout_cov: cover property (to_expire);

endmodule // i2cs_slave

`default_nettype wire

// [tb/i2cs_master_model.sv]
/*
  Behavioural two-wire bus master with open-drain outputs, 1 releases a line.
  Assumes pull-ups, so a released line reads 1 unless the slave pulls it low.
*/
`default_nettype none

module i2cs_master_model (
  input  wire logic ref_clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_drv,
  output logic      stuck
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    stuck = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask

  // Releases SCL and waits, bounded, while the slave stretches it.
  task automatic rise();
    int n;
    scl_drv <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (scl !== 1'b1 && n < 2000);
    if (n >= 2000) stuck <= 1'b1;
    half();
  endtask

  task automatic start_cond();
    sda_drv <= 1'b1;
    half();
    rise();
    sda_drv <= 1'b0;
    half();
    scl_drv <= 1'b0;
    half();
  endtask

  task automatic stop_cond();
    sda_drv <= 1'b0;
    half();
    rise();
    sda_drv <= 1'b1;
    half();
  endtask

  task automatic bit_xfer(input logic b, output logic r);
    sda_drv <= b;
    half();
    rise();
    r = sda;
    scl_drv <= 1'b0;
    half();
  endtask

  task automatic byte_xfer(input logic [7:0] d, input logic ack,
                           output logic [7:0] q, output logic ackr);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], q[i]);
    end
    bit_xfer(ack, ackr);
  endtask
endmodule // i2cs_master_model

`default_nettype wire

// [tb/i2c_slave_addr_ack_timeout_bench.sv]
/*
  Self-checking bench for the two-wire slave: APB master tasks and scenarios.
  Assumes the master model in i2cs_master_model and the package constants.
*/
`default_nettype none

module i2c_slave_addr_ack_timeout_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk, rst, psel, penable, pwrite, sub_tick, err;
  logic [7:0]  paddr, q8;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, bus_irq;
  logic        scl, sda, scl_drv, sda_drv, stuck, a;
  int          failures = 0;
  int          checks_done = 0;
  int          irqs = 0;
  int          i0, n;

  assign scl = scl_drv & (scl_oe_n | scl_out);
  assign sda = sda_drv & (sda_oe_n | sda_out);

  i2cs_slave i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out,
    .sda_oe_n, .sub_tick, .bus_irq);
  i2cs_master_model i_master (.ref_clk, .scl, .sda, .scl_drv, .sda_drv, .stuck);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (bus_irq === 1'b1) irqs <= irqs + 1;
  always @(posedge stuck) begin
    failures++;
    complete_run();
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      complete_run();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    apb(0, i2cs_pkg::OFS_CTRL1, 0);
    chk(q, 0, "ctrl1 reset");
    apb(0, i2cs_pkg::OFS_TOCTRL, 0);
    chk(q, 0, "toctrl reset");
    apb(1, 8'h14, 32'hFF);
    apb(0, 8'h14, 0);
    chk({q, err}, 33'h1, "unmapped");
    $display("done regs");
  endtask

  task automatic t_write();
    i0 = irqs;
    i_master.start_cond();
    i_master.byte_xfer(8'hB4, 1'b1, q8, a);
    chk(a, 0, "addr ack");
    chk(irqs - i0, 1, "match irq");
    chk(scl_oe_n, 0, "stretch");
    apb(0, i2cs_pkg::OFS_CTRL1, 0);
    chk(q & 32'h64, 32'h60, "ctrl1 flags");
    apb(0, i2cs_pkg::OFS_DATA, 0);
    i_master.byte_xfer(8'hC3, 1'b1, q8, a);
    chk(a, 0, "data ack");
    chk(irqs - i0, 2, "byte irq");
    apb(0, i2cs_pkg::OFS_DATA, 0);
    chk(q, 32'hC3, "rx byte");
    apb(1, i2cs_pkg::OFS_CTRL1, 32'h08);
    i_master.byte_xfer(8'h35, 1'b1, q8, a);
    chk(a, 1, "ack to send high");
    apb(0, i2cs_pkg::OFS_DATA, 0);
    chk(q, 32'h35, "second rx byte");
    i_master.stop_cond();
    $display("done write");
  endtask

  task automatic t_read();
    i_master.start_cond();
    i_master.byte_xfer(8'hB5, 1'b1, q8, a);
    apb(0, i2cs_pkg::OFS_CTRL1, 0);
    chk(q & 32'h64, 32'h64, "read flag");
    apb(1, i2cs_pkg::OFS_CTRL1, 32'h10);
    apb(1, i2cs_pkg::OFS_DATA, 32'h96);
    i_master.byte_xfer(8'hFF, 1'b0, q8, a);
    chk(q8, 8'h96, "tx byte");
    apb(0, i2cs_pkg::OFS_CTRL1, 0);
    chk({q[0], scl_oe_n}, 0, "ack flag and stretch");
    apb(1, i2cs_pkg::OFS_DATA, 32'h69);
    i_master.byte_xfer(8'hFF, 1'b1, q8, a);
    chk(q8, 8'h69, "second tx byte");
    apb(0, i2cs_pkg::OFS_CTRL1, 0);
    chk(q & 32'h1, 1, "nack flag");
    chk(sda_oe_n, 1, "sda freed");
    i_master.stop_cond();
    $display("done read");
  endtask

  task automatic t_miss();
    i0 = irqs;
    i_master.start_cond();
    i_master.byte_xfer(8'h66, 1'b1, q8, a);
    chk({a, 32'(irqs - i0)}, 33'h100000000, "no ack no irq");
    i_master.stop_cond();
    $display("done miss");
  endtask

  task automatic t_tout();
    apb(1, i2cs_pkg::OFS_TOCTRL, 32'h82);
    sub_tick <= 1'b1;
    i_master.start_cond();
    i_master.byte_xfer(8'hB4, 1'b1, q8, a);
    i0 = irqs;
    n = 0;
    while (irqs == i0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n > 80 && n < 110, 1, "period");
    apb(0, i2cs_pkg::OFS_TOCTRL, 0);
    chk(q, 32'h42, "flag set");
    apb(0, i2cs_pkg::OFS_CTRL1, 0);
    chk({q, scl_oe_n}, 33'h1, "ctrl1 reset");
    apb(0, i2cs_pkg::OFS_ADDR, 0);
    chk(q, 32'hB4, "addr kept");
    apb(1, i2cs_pkg::OFS_TOCTRL, 32'h02);
    apb(0, i2cs_pkg::OFS_TOCTRL, 0);
    chk(q, 32'h02, "flag clear");
    i_master.stop_cond();
    $display("done timeout");
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sub_tick = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1, i2cs_pkg::OFS_CTRL0, 32'h01);
    apb(1, i2cs_pkg::OFS_ADDR, 32'hB4);
    t_regs();
    t_write();
    t_read();
    t_miss();
    t_tout();
    complete_run();
  end
endmodule // i2c_slave_addr_ack_timeout_bench

`default_nettype wire
